// ### hdl/dct_timers.sv
`timescale 1ns/10ps
`include "dct_map.svh"

// Contract
// - Two timers, four modes, independent selection
// - Timebase is system clock or prescaled
// - Counter mode counts falling event edges
// - Count held as low and high bytes
// - Interrupt forwarded only when enabled
// - 13-bit uses high byte, low five bits
// - 13-bit wrap sets overflow flag
// - 16-bit and 8-bit reload modes exist
// - Split low byte uses timer0 controls
// - Split high byte is timer only
// - Split high byte uses timer1 run, flag
// - Timer1 under split: no event, no flag
// - Timer1 under split runs unless mode split
module dct_timers (
	input wire logic clock, // System clock, 50 MHz
	input wire logic rst_n, // Synchronous reset
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic sfr_wr, // Register write strobe
	input wire logic sfr_rd, // Register read strobe
	input wire logic [7:0] sfr_wdata, // Write data
	output logic [7:0] sfr_rdata, // Read data, registered
	input wire logic event_input_pin_a, // Timer0 event input
	input wire logic event_input_pin_b, // Timer1 event input
	input wire logic gate_input_a, // Timer0 gate input, active high
	input wire logic gate_input_b, // Timer1 gate input, active high
	output logic timer0_irq, // Timer0 interrupt request
	output logic timer1_irq, // Timer1 interrupt request
	output logic timer0_overflow, // Timer0 overflow pulse
	output logic timer1_overflow // Timer1 overflow pulse
);
	import dct_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] timer0_low_byte_r, timer0_high_byte_r;
	logic [7:0] timer1_low_byte_r, timer1_high_byte_r;
	logic [7:0] timer_control_register_r, timer_mode_register_r;
	logic [7:0] clock_control_r, interrupt_enable_register_r;
	logic [7:0] rdata_r;
	logic pin_a_prev_r, pin_b_prev_r;
	logic ov0_r, ov1_r;

	dct_mode_t mode0, mode1;
	logic pre_tick, fall_a, fall_b, split;
	logic tick0, tick1, tick0h, run0, run1, run0h;
	logic [16:0] step0, step1;
	logic [8:0] step0h;
	logic set_tf0, set_tf1, t1_ovf;

	// Returns {overflow, high, low} after one count
	function automatic logic [16:0] dct_step(dct_mode_t m, logic [7:0] hi, logic [7:0] lo);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8 = {1'b0, lo} + 9'h001;
		case (m)
			DCT_MODE_13: dct_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
			DCT_MODE_16: dct_step = c16;
			DCT_MODE_RELOAD: dct_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
			default: dct_step = {c8[8], hi, c8[7:0]};
		endcase
	endfunction

	dct_prescale u_prescale (
		.clock(clock),
		.rst_n(rst_n),
		.sel(clock_control_r[`DCT_CK_SCA_HI:`DCT_CK_SCA_LO]),
		.tick(pre_tick)
	);

	// ----------------------------------------------------------------
	// Count enables
	// ----------------------------------------------------------------
	assign mode0 = dct_mode_t'(timer_mode_register_r[`DCT_MD_M0_HI:`DCT_MD_M0_LO]);
	assign mode1 = dct_mode_t'(timer_mode_register_r[`DCT_MD_M1_HI:`DCT_MD_M1_LO]);
	assign split = (mode0 == DCT_MODE_SPLIT);
	assign fall_a = pin_a_prev_r && !event_input_pin_a;
	assign fall_b = pin_b_prev_r && !event_input_pin_b;

	always_comb begin
		tick0 = timer_mode_register_r[`DCT_MD_CT0] ? fall_a
			: (clock_control_r[`DCT_CK_T0M] || pre_tick);
		tick0h = clock_control_r[`DCT_CK_T1M] || pre_tick;
		if (split) begin
			tick1 = clock_control_r[`DCT_CK_T1M] || pre_tick;
		end else begin
			tick1 = timer_mode_register_r[`DCT_MD_CT1] ? fall_b
				: (clock_control_r[`DCT_CK_T1M] || pre_tick);
		end
	end

	assign run0 = timer_control_register_r[`DCT_CTRL_RUN0] && tick0
		&& (!timer_mode_register_r[`DCT_MD_GATE_0] || gate_input_a);
	assign run0h = split && timer_control_register_r[`DCT_CTRL_RUN1] && tick0h;
	assign run1 = split ? (mode1 != DCT_MODE_SPLIT) && tick1
		: timer_control_register_r[`DCT_CTRL_RUN1] && tick1 && (mode1 != DCT_MODE_SPLIT)
		&& (!timer_mode_register_r[`DCT_MD_GATE_1] || gate_input_b);

	assign step0 = dct_step(mode0, timer0_high_byte_r, timer0_low_byte_r);
	assign step1 = dct_step(mode1, timer1_high_byte_r, timer1_low_byte_r);
	assign step0h = {1'b0, timer0_high_byte_r} + 9'h001;

	assign t1_ovf = run1 && step1[16];
	assign set_tf0 = run0 && step0[16];
	assign set_tf1 = split ? (run0h && step0h[8]) : t1_ovf;

	// ----------------------------------------------------------------
	// Event pin history
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_a_prev_r <= 1'b1;
			pin_b_prev_r <= 1'b1;
		end else begin
			pin_a_prev_r <= event_input_pin_a;
			pin_b_prev_r <= event_input_pin_b;
		end
	end

	// ----------------------------------------------------------------
	// Timer0 count bytes; software write wins over counting
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer0_low_byte_r <= `DCT_RST_BYTE;
		end else if (sfr_wr && sfr_addr == `DCT_ADDR_LO0) begin
			timer0_low_byte_r <= sfr_wdata;
		end else if (run0) begin
			timer0_low_byte_r <= step0[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer0_high_byte_r <= `DCT_RST_BYTE;
		end else if (sfr_wr && sfr_addr == `DCT_ADDR_HI0) begin
			timer0_high_byte_r <= sfr_wdata;
		end else if (run0h) begin
			timer0_high_byte_r <= step0h[7:0];
		end else if (run0 && !split) begin
			timer0_high_byte_r <= step0[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Timer1 count bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer1_low_byte_r <= `DCT_RST_BYTE;
			timer1_high_byte_r <= `DCT_RST_BYTE;
		end else begin
			if (sfr_wr && sfr_addr == `DCT_ADDR_LO1) begin
				timer1_low_byte_r <= sfr_wdata;
			end else if (run1) begin
				timer1_low_byte_r <= step1[7:0];
			end
			if (sfr_wr && sfr_addr == `DCT_ADDR_HI1) begin
				timer1_high_byte_r <= sfr_wdata;
			end else if (run1) begin
				timer1_high_byte_r <= step1[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register; hardware flag set wins over software clear
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_control_register_r <= `DCT_RST_BYTE;
		end else begin
			if (sfr_wr && sfr_addr == `DCT_ADDR_CTRL) begin
				timer_control_register_r <= sfr_wdata;
			end
			if (set_tf0) begin
				timer_control_register_r[`DCT_CTRL_FLAG0] <= 1'b1;
			end
			if (set_tf1) begin
				timer_control_register_r[`DCT_CTRL_FLAG1] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_mode_register_r <= `DCT_RST_BYTE;
			clock_control_r <= `DCT_RST_BYTE;
			interrupt_enable_register_r <= `DCT_RST_BYTE;
		end else if (sfr_wr) begin
			if (sfr_addr == `DCT_ADDR_MODE) begin
				timer_mode_register_r <= sfr_wdata;
			end
			if (sfr_addr == `DCT_ADDR_CKCON) begin
				clock_control_r <= sfr_wdata;
			end
			if (sfr_addr == `DCT_ADDR_IRQEN) begin
				interrupt_enable_register_r <= sfr_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data and overflow pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= `DCT_RST_BYTE;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`DCT_ADDR_CTRL: rdata_r <= timer_control_register_r;
				`DCT_ADDR_MODE: rdata_r <= timer_mode_register_r;
				`DCT_ADDR_LO0: rdata_r <= timer0_low_byte_r;
				`DCT_ADDR_LO1: rdata_r <= timer1_low_byte_r;
				`DCT_ADDR_HI0: rdata_r <= timer0_high_byte_r;
				`DCT_ADDR_HI1: rdata_r <= timer1_high_byte_r;
				`DCT_ADDR_CKCON: rdata_r <= clock_control_r;
				`DCT_ADDR_IRQEN: rdata_r <= interrupt_enable_register_r;
				default: rdata_r <= `DCT_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ov0_r <= 1'b0;
			ov1_r <= 1'b0;
		end else begin
			ov0_r <= set_tf0;
			ov1_r <= t1_ovf;
		end
	end

	assign sfr_rdata = rdata_r;
	assign timer0_overflow = ov0_r;
	assign timer1_overflow = ov1_r;
	assign timer0_irq = timer_control_register_r[`DCT_CTRL_FLAG0]
		&& interrupt_enable_register_r[`DCT_IRQEN_TMR0];
	assign timer1_irq = timer_control_register_r[`DCT_CTRL_FLAG1]
		&& interrupt_enable_register_r[`DCT_IRQEN_TMR1];
endmodule

// ### hdl/dct_map.svh
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DCT_ADDR_CTRL 8'h88
`define DCT_ADDR_MODE 8'h89
`define DCT_ADDR_LO0 8'h8a
`define DCT_ADDR_LO1 8'h8b
`define DCT_ADDR_HI0 8'h8c
`define DCT_ADDR_HI1 8'h8d
`define DCT_ADDR_CKCON 8'h8e
`define DCT_ADDR_IRQEN 8'ha8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCT_RST_BYTE 8'h00

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DCT_CTRL_FLAG1 7
`define DCT_CTRL_RUN1 6
`define DCT_CTRL_FLAG0 5
`define DCT_CTRL_RUN0 4

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define DCT_MD_GATE_1 7
`define DCT_MD_CT1 6
`define DCT_MD_M1_HI 5
`define DCT_MD_M1_LO 4
`define DCT_MD_GATE_0 3
`define DCT_MD_CT0 2
`define DCT_MD_M0_HI 1
`define DCT_MD_M0_LO 0

// ----------------------------------------------------------------
// Clock select and interrupt enable fields
// ----------------------------------------------------------------
`define DCT_CK_T1M 3
`define DCT_CK_T0M 2
`define DCT_CK_SCA_HI 1
`define DCT_CK_SCA_LO 0
`define DCT_IRQEN_TMR1 3
`define DCT_IRQEN_TMR0 1

// ----------------------------------------------------------------
// Prescale ratios and counter masks
// ----------------------------------------------------------------
`define DCT_DIV_SCA0 12
`define DCT_DIV_SCA1 4
`define DCT_DIV_SCA2 48
`define DCT_DIV_SCA3 8
`define DCT_LO5_MASK 8'h1f
`define DCT_LO5_TOP 5'h1f
`define DCT_BYTE_TOP 8'hff
`define DCT_HALF_TOP 16'hffff

`endif

// ### hdl/dct_pkg.sv
package dct_pkg;
	typedef enum logic [1:0] {
		DCT_MODE_13 = 2'b00,
		DCT_MODE_16 = 2'b01,
		DCT_MODE_RELOAD = 2'b10,
		DCT_MODE_SPLIT = 2'b11
	} dct_mode_t;
endpackage

// ### hdl/dct_prescale.sv
`timescale 1ns/10ps
`include "dct_map.svh"

module dct_prescale #(
	parameter int DIV0 = `DCT_DIV_SCA0,
	parameter int DIV1 = `DCT_DIV_SCA1,
	parameter int DIV2 = `DCT_DIV_SCA2,
	parameter int DIV3 = `DCT_DIV_SCA3
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Synchronous reset
	input wire logic [1:0] sel, // Prescale select bits
	output logic tick // One-cycle enable pulse
);
	logic [7:0] cnt_r;
	logic [7:0] last;

	always_comb begin
		case (sel)
			2'b00: last = 8'(DIV0 - 1);
			2'b01: last = 8'(DIV1 - 1);
			2'b10: last = 8'(DIV2 - 1);
			default: last = 8'(DIV3 - 1);
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
		end else if (cnt_r >= last) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign tick = rst_n && (cnt_r >= last);
endmodule

// ### tb/dct_event_src.sv
`timescale 1ns/10ps

module dct_event_src (
	input wire logic clock, // System clock
	output logic pin // Event line, idles high
);
	initial pin = 1'b1;

	// -------------------------------
	// Falling edges, five cycles each
	// -------------------------------
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clock) pin <= 1'b0;
			repeat (2) @(posedge clock);
			pin <= 1'b1;
			repeat (2) @(posedge clock);
		end
	endtask
endmodule

// ### tb/dct_timers_chk.sv
`timescale 1ns/10ps
`include "dct_map.svh"

module dct_timers_chk (
	input wire logic clock, // Clock
	input wire logic rst_n, // Reset
	input wire logic [7:0] sfr_addr, // Address
	input wire logic sfr_wr, // Write
	input wire logic sfr_rd, // Read
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic timer0_irq, // Irq 0
	input wire logic timer1_irq, // Irq 1
	input wire logic timer0_overflow, // Pulse 0
	input wire logic timer1_overflow // Pulse 1
);
	logic [7:0] en_r;
	logic [1:0] run_r;
	logic [1:0] md_r;
	logic mapped;

	assign mapped = sfr_addr inside {`DCT_ADDR_CTRL, `DCT_ADDR_MODE, `DCT_ADDR_LO0,
		`DCT_ADDR_LO1, `DCT_ADDR_HI0, `DCT_ADDR_HI1, `DCT_ADDR_CKCON, `DCT_ADDR_IRQEN};

	// ---------------------------------
	// Shadows of software-owned bits
	// ---------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			en_r <= 8'h00;
			run_r <= 2'h0;
			md_r <= 2'h0;
		end else if (sfr_wr) begin
			if (sfr_addr == `DCT_ADDR_IRQEN)
				en_r <= sfr_wdata;
			if (sfr_addr == `DCT_ADDR_CTRL)
				run_r <= {sfr_wdata[6], sfr_wdata[4]};
			if (sfr_addr == `DCT_ADDR_MODE)
				md_r <= sfr_wdata[1:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_irq0_enable: assert property (timer0_irq |-> en_r[1])
		else $error("timer0 irq without enable");
	chk_irq1_enable: assert property (timer1_irq |-> en_r[3])
		else $error("timer1 irq without enable");
	chk_irq0_cause: assert property ($rose(timer0_irq) && !$past(sfr_wr) |->
		##[0:1] (timer0_overflow || $past(timer0_overflow)))
		else $error("timer0 irq rose without overflow");
	chk_ovf0_run: assert property (timer0_overflow |->
		$past(run_r[0]))
		else $error("timer0 overflow while stopped");
	chk_ovf1_run: assert property (timer1_overflow |->
		$past(run_r[1]) || $past(md_r) == 2'h3)
		else $error("timer1 overflow while stopped");
	chk_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
		sfr_rdata == 8'h00 && !timer0_irq && !timer1_irq && !timer0_overflow)
		else $error("outputs not cleared by reset");

	cover property (timer0_overflow && timer0_irq);
	cover property (timer1_irq);
	cover property (timer1_overflow && !timer1_irq);
endmodule

bind dct_timers dct_timers_chk CHK (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
	.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow));

// ### tb/tb_dct_timers.sv
`timescale 1ns/10ps
`include "dct_map.svh"

module tb_dct_timers;
	logic clock, rst_n, sfr_wr, sfr_rd, gate_input_a, gate_input_b;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, w;
	logic ea, eb, timer0_irq, timer1_irq, timer0_overflow, timer1_overflow;
	int err_count = 0;
	int n_tests = 0;
	int k;

	dct_timers DUT (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.event_input_pin_a(ea), .event_input_pin_b(eb), .gate_input_a(gate_input_a),
		.gate_input_b(gate_input_b), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
		.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow));
	dct_event_src EVA (.clock(clock), .pin(ea));
	dct_event_src EVB (.clock(clock), .pin(eb));

	// -------------------------
	// Bus cycles and compare
	// -------------------------
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
		@(posedge clock) sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock) {sfr_rd, sfr_addr} <= {1'b1, a};
		@(posedge clock) sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask
	task automatic chk(input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic run_cnt(input logic [7:0] md, th, tl, input int n);
		wr(`DCT_ADDR_MODE, md);
		wr(`DCT_ADDR_HI0, th);
		wr(`DCT_ADDR_LO0, tl);
		wr(`DCT_ADDR_CTRL, 8'h10);
		EVA.pulse(n);
	endtask

	// -------------------------
	// Scenarios
	// -------------------------
	task automatic t_regs;
		rd(`DCT_ADDR_LO0, v); chk(v, `DCT_RST_BYTE);
		rd(`DCT_ADDR_HI1, v); chk(v, `DCT_RST_BYTE);
		rd(8'h80, v); chk(v, 8'h00);
		wr(`DCT_ADDR_HI1, 8'h5a);
		rd(`DCT_ADDR_HI1, v); chk(v, 8'h5a);
		$display("test regs done");
	endtask
	task automatic t_mode13;
		wr(`DCT_ADDR_IRQEN, 8'h02);
		run_cnt(8'h04, 8'hff, 8'hff, 1);
		rd(`DCT_ADDR_HI0, v); chk(v, 8'h00);
		rd(`DCT_ADDR_LO0, v); chk(v & `DCT_LO5_MASK, 8'h00);
		rd(`DCT_ADDR_CTRL, v); chk(v & 8'h20, 8'h20);
		chk({7'h0, timer0_irq}, 8'h01);
		wr(`DCT_ADDR_IRQEN, 8'h00);
		@(negedge clock);
		chk({7'h0, timer0_irq}, 8'h00);
		wr(`DCT_ADDR_CTRL, 8'h00);
		$display("test mode13 done");
	endtask
	task automatic t_mode16_reload;
		run_cnt(8'h05, 8'h00, 8'hfe, 3);
		wr(`DCT_ADDR_CTRL, 8'h00);
		rd(`DCT_ADDR_HI0, v); chk(v, 8'h01);
		rd(`DCT_ADDR_LO0, v); chk(v, 8'h01);
		run_cnt(8'h06, 8'h80, 8'hfe, 3);
		rd(`DCT_ADDR_CTRL, w); chk(w & 8'h20, 8'h20);
		wr(`DCT_ADDR_CTRL, 8'h00);
		rd(`DCT_ADDR_LO0, v); chk(v, 8'h81);
		rd(`DCT_ADDR_HI0, v); chk(v, 8'h80);
		$display("test mode16 reload done");
	endtask
	task automatic t_gate;
		@(posedge clock) gate_input_a <= 1'b0;
		run_cnt(8'h0d, 8'h00, 8'h00, 2);
		gate_input_a <= 1'b1;
		EVA.pulse(3);
		wr(`DCT_ADDR_CTRL, 8'h00);
		rd(`DCT_ADDR_LO0, v); chk(v, 8'h03);
		$display("test gate done");
	endtask
	task automatic t_clock;
		int dv[5] = '{12, 4, 48, 8, 1};
		int e;
		for (int i = 0; i < 5; i++) begin
			// Counting spans 96 waits plus the two edges of the stop write
			e = 98 / dv[i];
			wr(`DCT_ADDR_CKCON, (i < 4) ? 8'(i) : 8'h04);
			run_cnt(8'h01, 8'h00, 8'h00, 0);
			repeat (96) @(posedge clock);
			wr(`DCT_ADDR_CTRL, 8'h00);
			rd(`DCT_ADDR_LO0, v);
			chk({7'h0, v >= 8'(e - 1) && v <= 8'(e + 1)}, 8'h01);
		end
		$display("test clock done");
	endtask
	task automatic t_split;
		wr(`DCT_ADDR_IRQEN, 8'h08);
		wr(`DCT_ADDR_CKCON, 8'h04);
		wr(`DCT_ADDR_MODE, 8'h07);
		wr(`DCT_ADDR_HI0, 8'hfe);
		wr(`DCT_ADDR_LO0, 8'hfe);
		wr(`DCT_ADDR_CTRL, 8'h50);
		EVA.pulse(2);
		for (k = 0; k < 200 && timer1_irq !== 1'b1; k++) @(posedge clock);
		chk({7'h0, timer1_irq}, 8'h01);
		rd(`DCT_ADDR_CTRL, v); chk(v & 8'ha0, 8'ha0);
		wr(`DCT_ADDR_CTRL, 8'h00);
		rd(`DCT_ADDR_LO0, v); chk(v, 8'h00);
		wr(`DCT_ADDR_CKCON, 8'h0c);
		wr(`DCT_ADDR_HI1, 8'hff);
		wr(`DCT_ADDR_MODE, 8'h67);
		for (k = 0; k < 600 && timer1_overflow !== 1'b1; k++) @(posedge clock);
		chk({7'h0, timer1_overflow}, 8'h01);
		rd(`DCT_ADDR_CTRL, v); chk(v & 8'h80, 8'h00);
		wr(`DCT_ADDR_MODE, 8'h37);
		rd(`DCT_ADDR_LO1, v);
		EVB.pulse(2);
		rd(`DCT_ADDR_LO1, w); chk(w, v);
		$display("test split done");
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (8000) @(posedge clock);
		err_count++;
		print_verdict();
	end
	initial begin
		{rst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
		{gate_input_a, gate_input_b} = 2'b11;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_mode13();
		t_mode16_reload();
		t_gate();
		t_clock();
		t_split();
		print_verdict();
	end
endmodule
